/* File: verilog/nds_host.sv */
// Purpose: host controller reading nand die status over the async bus
// Assumes: one target; user issues a request and waits for done
// Notes:   live mode holds chip select and read strobe low for tracking
`timescale 1ns/1ps
module nds_host #(
  parameter int STROBE_CYC = nds_pkg::STROBE_CYC,
  parameter int WHR_CYC    = nds_pkg::WHR_CYC
) (
  input  wire logic                 CORE_CLK,
  input  wire logic                 SYS_RST,
  input  wire logic                 REQ_VALID,
  output logic                      REQ_READY,
  input  wire nds_pkg::nds_req_t    REQ,
  input  wire logic                 LIVE_STOP,
  output logic                      STAT_VALID,
  output nds_pkg::nds_status_t      STAT,
  output logic                      BUSY_N,
  output nds_pkg::nds_pins_t        PINS,
  input  wire logic [7:0]           DQ_IN,
  input  wire logic                 RB_N
);
  // refuse timing counts the 4-bit counter cannot hold, sync cycles included
  if (STROBE_CYC < 1 || STROBE_CYC > 13 || WHR_CYC < 1 || WHR_CYC > 15) begin : g_bad_timing
    $error("nds_host: timing counts out of range");
  end

  nds_pkg::nds_state_t state, next_state;
  nds_pkg::nds_req_t   req, next_req;
  nds_pkg::nds_pins_t  pins, next_pins;
  nds_pkg::nds_status_t stat, next_stat;
  logic [3:0]          cnt, next_cnt;
  logic [1:0]          acyc, next_acyc;
  logic                phase, next_phase;
  logic                sv, next_sv;
  logic [8:0]          sync_q;

  // decode a status byte; bit2 is ignored
  function automatic nds_pkg::nds_status_t decode(input logic [7:0] b);
    nds_pkg::nds_status_t s;
    s.write_open         = b[nds_pkg::BIT_WP_N];                  // RULE7
    s.ready              = b[nds_pkg::BIT_RDY];                   // RULE7
    s.array_ready        = b[nds_pkg::BIT_ARRAY_READY];                  // RULE8
    s.ecc_level          = {b[nds_pkg::BIT_ECC_HI], b[nds_pkg::BIT_ECC_LO]}; // RULE9
    s.prior_program_fail = b[nds_pkg::BIT_PRIOR_PROGRAM_FAIL] & b[nds_pkg::BIT_RDY];      // RULE11
    s.fail               = b[nds_pkg::BIT_FAIL] & b[nds_pkg::BIT_ARRAY_READY];      // RULE12 RULE13
    return s;
  endfunction : decode

  function automatic logic [3:0] cyc4(input int n);
    return n[3:0];
  endfunction : cyc4

  // bus inputs cross into core clock
  nds_sync #(.WIDTH(9)) u_sync (
    .CORE_CLK (CORE_CLK),
    .SYS_RST  (SYS_RST),
    .async_in ({RB_N, DQ_IN}),
    .sync_out (sync_q)
  );

  // sequencer next values
  always_comb begin
    next_state = state;
    next_req   = req;
    next_pins  = pins;
    next_stat  = stat;
    next_cnt   = cnt;
    next_acyc  = acyc;
    next_phase = phase;
    next_sv    = 1'b0;
    case (state)
      nds_pkg::ST_IDLE: begin
        next_pins.ce_n          = 1'b1;
        next_pins.read_strobe_n = 1'b1;
        next_pins.dq_oe_n       = 1'b1;
        if (REQ_VALID) begin
          next_req   = REQ;
          next_state = nds_pkg::ST_CMD;
          next_phase = 1'b0;
          next_cnt   = cyc4(STROBE_CYC);
          next_pins.ce_n    = 1'b0;
          next_pins.cle     = 1'b1;
          next_pins.we_n    = 1'b0;
          next_pins.dq_oe_n = 1'b0;
          // RULE6 RULE16 enhanced status selects one die by row
          next_pins.dq_out  = REQ.enhanced ? nds_pkg::CMD_STATUS_ENH
                                           : nds_pkg::CMD_STATUS; // RULE5 RULE14 RULE20
        end
      end
      nds_pkg::ST_CMD, nds_pkg::ST_ADDR, nds_pkg::ST_EXIT: begin
        if (cnt > nds_pkg::CNT_ONE) next_cnt = cnt - nds_pkg::CNT_ONE;
        else if (!phase) begin
          next_pins.we_n = 1'b1; // latch edge
          next_phase     = 1'b1;
          next_cnt       = cyc4(STROBE_CYC);
        end else begin
          next_phase     = 1'b0;
          next_cnt       = cyc4(STROBE_CYC);
          next_pins.cle  = 1'b0;
          next_pins.ale  = 1'b0;
          if (state == nds_pkg::ST_CMD && req.enhanced) begin
            // RULE16 three row cycles: page, block, die
            next_state       = nds_pkg::ST_ADDR;
            next_acyc        = 2'h0;
            next_pins.ale    = 1'b1;
            next_pins.we_n   = 1'b0;
            next_pins.dq_out = req.row[7:0];
          end else if (state == nds_pkg::ST_ADDR &&
                       acyc != 2'(nds_pkg::ROW_CYCLES - 1)) begin
            next_acyc        = acyc + 2'h1;
            next_pins.ale    = 1'b1;
            next_pins.we_n   = 1'b0;
            next_pins.dq_out = (acyc == 2'h0) ? req.row[15:8] : req.row[23:16];
          end else if (state == nds_pkg::ST_EXIT) begin
            next_state        = nds_pkg::ST_DONE;
            next_pins.dq_oe_n = 1'b1;
          end else begin
            next_state        = nds_pkg::ST_WAIT;
            next_pins.dq_oe_n = 1'b1;
            next_cnt          = cyc4(WHR_CYC);
          end
        end
      end
      nds_pkg::ST_WAIT: begin
        if (cnt > nds_pkg::CNT_ONE) next_cnt = cnt - nds_pkg::CNT_ONE;
        else begin
          next_state              = nds_pkg::ST_READ;
          next_pins.read_strobe_n = 1'b0; // RULE2 one read strobe
          next_cnt                = cyc4(STROBE_CYC) + nds_pkg::SYNC_CYC;
        end
      end
      nds_pkg::ST_READ: begin
        // wait strobe time plus two synchroniser cycles
        if (cnt > nds_pkg::CNT_ONE) next_cnt = cnt - nds_pkg::CNT_ONE;
        else begin
          next_stat = decode(sync_q[7:0]); // RULE1 RULE2
          next_sv   = 1'b1;
          if (req.live) next_state = nds_pkg::ST_LIVE;
          else begin
            next_pins.read_strobe_n = 1'b1;
            next_state              = nds_pkg::ST_DONE;
          end
        end
      end
      nds_pkg::ST_LIVE: begin
        // RULE3 strobe held low, byte tracked without new edges
        next_stat = decode(sync_q[7:0]);
        next_sv   = (decode(sync_q[7:0]) != stat);
        if (LIVE_STOP) begin
          next_pins.read_strobe_n = 1'b1;
          next_state              = nds_pkg::ST_DONE;
        end
      end
      nds_pkg::ST_DONE: begin
        if (req.to_read_mode) begin
          // RULE4 RULE19 leave status output for page data
          next_req.to_read_mode = 1'b0;
          next_state        = nds_pkg::ST_EXIT;
          next_phase        = 1'b0;
          next_cnt          = cyc4(STROBE_CYC);
          next_pins.cle     = 1'b1;
          next_pins.we_n    = 1'b0;
          next_pins.dq_oe_n = 1'b0;
          next_pins.dq_out  = nds_pkg::CMD_READ_MODE;
        end else next_state = nds_pkg::ST_IDLE;
      end
      default: next_state = nds_pkg::ST_IDLE;
    endcase
  end

  // register sequencer state
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state <= nds_pkg::ST_IDLE;
      req   <= '0;
      pins  <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                 read_strobe_n: 1'b1, dq_out: 8'h00, dq_oe_n: 1'b1};
      stat  <= '0;
      cnt   <= 4'h0;
      acyc  <= 2'h0;
      phase <= 1'b0;
      sv    <= 1'b0;
    end else begin
      state <= next_state;
      req   <= next_req;
      pins  <= next_pins;
      stat  <= next_stat;
      cnt   <= next_cnt;
      acyc  <= next_acyc;
      phase <= next_phase;
      sv    <= next_sv;
    end
  end

  // outputs
  assign REQ_READY  = (state == nds_pkg::ST_IDLE);
  assign STAT_VALID = sv;
  assign STAT       = stat;
  assign PINS       = pins;
  assign BUSY_N     = sync_q[8]; // RULE7 ready pin
endmodule : nds_host

/* File: verilog/nds_pkg.sv */
// Purpose: shared constants and types for the nand die status host controller
// Assumes: asynchronous byte-wide nand bus driven from a 25 MHz core clock
// Notes:   rule summary below
// Operation
// RULE1: each die keeps and reports its own 8-bit status byte independently.
// RULE2: after 70h or 78h the die drives status on every read strobe.
// RULE3: status output updates live while chip select and read strobe stay low.
// RULE4: host sends 00h after polling status to regain page data output.
// RULE5: 70h returns last-selected die status, accepted even while busy.
// RULE6: multi-die targets after interleaved work must use 78h, not 70h.
// RULE7: bit7 low means protected; bit6 low busy, high ready, pin follows.
// RULE8: bit5 high only once all internal array work has finished.
// RULE9: bits 4:3 report read ecc severity, zero for program and erase.
// RULE10: on-die ecc corrects up to seven or eight bits per sector.
// RULE11: bit1 holds previous program pass or fail, valid when bit6 high.
// RULE12: bit0 reports last finished operation failure, valid when bit5 high.
// RULE13: after a page read, bit0 flags an uncorrectable read error.
// RULE14: single-die target: 70h returns valid status after any command.
// RULE15: all dies accept 78h while busy; addressed die reports while busy.
// RULE16: 78h plus three row address cycles selects die until next command.
// RULE17: dies not matching the 78h row address leave the data bus.
// RULE18: ready bits shared per die; fail bits belong to addressed plane.
// RULE19: 78h enables die output; host sends 00h before reading page data.
// RULE20: host never sends 78h during power-on reset or otp mode.
// RULE21: column operations can select any byte of the cache register.
// RULE22: bit2 has no meaning and is driven zero.
package nds_pkg;
  localparam logic [7:0] CMD_READ_MODE   = 8'h00;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH  = 8'h78;
  localparam int         ROW_CYCLES      = 3;
  // status bit positions
  localparam int         BIT_WP_N        = 7;
  localparam int         BIT_RDY         = 6;
  localparam int         BIT_ARRAY_READY        = 5;
  localparam int         BIT_ECC_HI      = 4;
  localparam int         BIT_ECC_LO      = 3;
  localparam int         BIT_SPARE       = 2;
  localparam int         BIT_PRIOR_PROGRAM_FAIL       = 1;
  localparam int         BIT_FAIL        = 0;
  // bus timing in ns; 20 ns strobe and 60 ns command-to-read wait figures at 40 ns clock
  localparam int         CLK_NS          = 40;
  localparam int         T_STROBE_NS     = 20;
  localparam int         T_WHR_NS        = 60;
  localparam int         STROBE_CYC      = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int         WHR_CYC         = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] CNT_ONE         = 4'h1;
  // extra read-strobe cycles that cover the two synchroniser stages
  localparam logic [3:0] SYNC_CYC        = 4'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_CMD   = 4'b0001,
    ST_ADDR  = 4'b0010,
    ST_WAIT  = 4'b0011,
    ST_READ  = 4'b0100,
    ST_LIVE  = 4'b0101,
    ST_EXIT  = 4'b0110,
    ST_DONE  = 4'b0111
  } nds_state_t;

  // user order
  typedef struct packed {
    logic        enhanced;
    logic        live;
    logic        to_read_mode;
    logic [23:0] row;
  } nds_req_t;

  // decoded status
  typedef struct packed {
    logic       write_open;
    logic       ready;
    logic       array_ready;
    logic [1:0] ecc_level;
    logic       prior_program_fail;
    logic       fail;
  } nds_status_t;

  // bus pins driven by host
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic [7:0] dq_out;
    logic       dq_oe_n;
  } nds_pins_t;
endpackage : nds_pkg

/* File: verilog/nds_sync.sv */
// Purpose: two-flop synchroniser for bus inputs
// Assumes: inputs asynchronous to core clock
// Notes:   first stage read only by the second stage
`timescale 1ns/1ps
module nds_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             CORE_CLK,
  input  wire logic             SYS_RST,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  // next values of both stages
  always_comb begin
    next_stage1 = async_in;
    next_sync   = stage1;
  end

  // register stages
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync;
    end
  end
endmodule : nds_sync

/* File: tb/nds_host_assertions.sv */
// Purpose: port checks for the status host controller
// Assumes: bound to nds_host, one clock domain
// Notes:   row cycles counted on falling write strobe with ale high
`timescale 1ns/1ps
module nds_host_assertions #(
  parameter int STROBE_CYC = 1,
  parameter int WHR_CYC    = 2
) (
  input wire logic                 CORE_CLK,
  input wire logic                 SYS_RST,
  input wire logic                 REQ_VALID,
  input wire logic                 REQ_READY,
  input wire nds_pkg::nds_req_t    REQ,
  input wire logic                 STAT_VALID,
  input wire nds_pkg::nds_status_t STAT,
  input wire logic                 BUSY_N,
  input wire nds_pkg::nds_pins_t   PINS,
  input wire logic [7:0]           DQ_IN,
  input wire logic                 RB_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic [3:0] row_cnt, next_row_cnt;
  logic       we_q, enh, next_enh;
  wire        take = REQ_VALID && REQ_READY;
  // count row bytes of the current request
  always_comb begin
    next_row_cnt = row_cnt;
    next_enh     = enh;
    if (take) begin
      next_row_cnt = 4'h0;
      next_enh     = REQ.enhanced;
    end else if (PINS.ale && !PINS.we_n && we_q) begin
      next_row_cnt = row_cnt + 4'h1;
    end
  end
  // register helper state
  always_ff @(posedge CORE_CLK) begin
    row_cnt <= SYS_RST ? 4'h0 : next_row_cnt;
    enh     <= SYS_RST ? 1'b0 : next_enh;
    we_q    <= SYS_RST ? 1'b1 : PINS.we_n;
  end
  chk_plain_cmd: assert property (take && !REQ.enhanced |=> PINS.cle && !PINS.ce_n
    && PINS.dq_out == 8'h70 && !PINS.dq_oe_n) else $error("plain status command wrong");
  chk_enh_cmd: assert property (take && REQ.enhanced |=> PINS.cle && !PINS.ce_n
    && PINS.dq_out == 8'h78 && !PINS.dq_oe_n) else $error("enhanced command wrong");
  chk_row_cycles: assert property (STAT_VALID |-> row_cnt == (enh ? 4'h3 : 4'h0))
    else $error("row byte count wrong");
  chk_no_fight: assert property (!PINS.read_strobe_n |-> PINS.dq_oe_n)
    else $error("host drives bus while reading");
  chk_turn_wait: assert property ($fell(PINS.cle) |-> PINS.read_strobe_n [*2])
    else $error("read strobe too soon after command");
  chk_fail_mask: assert property (STAT_VALID && !STAT.array_ready |-> !STAT.fail)
    else $error("fail shown while array busy");
  chk_prior_program_fail_mask: assert property (STAT_VALID && !STAT.ready |-> !STAT.prior_program_fail)
    else $error("prior fail shown while busy");
  chk_answer_time: assert property (take && !REQ.live |-> ##[4:40] STAT_VALID)
    else $error("status answer late");
  chk_busy_pin: assert property ($changed(RB_N) |-> ##[1:3] BUSY_N == RB_N)
    else $error("busy output does not follow pin");
  chk_live_track: assert property ((!PINS.read_strobe_n && !PINS.ce_n) [*2] ##0
    $changed(DQ_IN) |-> ##[1:6] STAT_VALID) else $error("live change not reported");
  cover property (take && REQ.enhanced);
  cover property (take && REQ.live);
  cover property (STAT_VALID && STAT.fail);
endmodule : nds_host_assertions

/* File: tb/nds_die_model.sv */
// Purpose: behavioural die answering status commands
// Assumes: commands and row bytes latched on rising write strobe
// Notes:   status byte supplied by the bench; die bit is row bit 16
`timescale 1ns/1ps
module nds_die_model #(
  parameter logic DIE_ID = 1'b0
) (
  input  wire nds_pkg::nds_pins_t PINS,
  input  wire logic [7:0]         STATUS,
  output logic [7:0]              DQ,
  output logic                    DRIVE,
  output logic                    RB_N,
  output logic                    DATA_ON
);
  logic       sel = !DIE_ID;
  logic       stat_on = 1'b0;
  logic       enh = 1'b0;
  logic [1:0] cnt = 2'h0;
  initial DATA_ON = 1'b0;
  // command and row byte decode, accepted even while busy
  always @(posedge PINS.we_n) begin
    if (!PINS.ce_n && PINS.cle) begin
      stat_on <= sel && PINS.dq_out == 8'h70;
      enh     <= PINS.dq_out == 8'h78;
      DATA_ON <= PINS.dq_out == 8'h00;
      cnt     <= 2'h0;
    end else if (!PINS.ce_n && PINS.ale && enh) begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h2) begin
        sel     <= PINS.dq_out[0] == DIE_ID;
        stat_on <= PINS.dq_out[0] == DIE_ID;
        enh     <= 1'b0;
      end
    end
  end
  // live status output while selected and strobed
  assign DRIVE = stat_on && !PINS.ce_n && !PINS.read_strobe_n;
  assign DQ    = {STATUS[7:3], 1'b0, STATUS[1:0]};
  assign RB_N  = STATUS[6];
endmodule : nds_die_model

/* File: tb/nds_host_bench.sv */
// Purpose: self-checking bench for the status host controller
// Assumes: two die models share the data bus and ready pin
// Notes:   driver queues expected status, monitor compares
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module nds_host_bench;
  logic                 clk = 0, rst = 1, req_valid = 0, live_stop = 0;
  logic                 req_ready, stat_valid, busy_n, rb_n, d0, d1, rb0, rb1, dm0, dm1;
  logic [7:0]           dq_in, q0, q1, s0 = 8'he0, s1 = 8'he0, last_dq = 8'h00;
  nds_pkg::nds_req_t    req = '0;
  nds_pkg::nds_status_t stat;
  nds_pkg::nds_pins_t   pins;
  nds_pkg::nds_status_t exp_q[$], exp_s;
  int                   fails = 0, n_tests = 0, k, seed = 32'ha2deea96;
  initial forever #20 clk = ~clk;
  // released bus shows the inverse of its last value
  assign dq_in = d0 ? q0 : (d1 ? q1 : ~last_dq);
  assign rb_n = rb0 & rb1;
  always @(posedge clk) if (d0 || d1) last_dq <= dq_in;
  nds_host i_nds_host (.CORE_CLK(clk), .SYS_RST(rst), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ(req), .LIVE_STOP(live_stop), .STAT_VALID(stat_valid),
    .STAT(stat), .BUSY_N(busy_n), .PINS(pins), .DQ_IN(dq_in), .RB_N(rb_n));
  nds_die_model #(.DIE_ID(1'b0)) i_nds_die_model_0 (.PINS(pins), .STATUS(s0), .DQ(q0),
    .DRIVE(d0), .RB_N(rb0), .DATA_ON(dm0));
  nds_die_model #(.DIE_ID(1'b1)) i_nds_die_model_1 (.PINS(pins), .STATUS(s1), .DQ(q1),
    .DRIVE(d1), .RB_N(rb1), .DATA_ON(dm1));
  // monitor: one queued note per status result, no two dies on the bus
  always @(posedge clk) begin
    if (d0 && d1) `CHK("bus_fight", 1'b0, 1'b1)
    if (stat_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK("stat_extra", 1'b0, 1'b1)
      else begin
        exp_s = exp_q.pop_front();
        `CHK("stat", exp_s, stat)
      end
    end
  end
  function automatic nds_pkg::nds_status_t dec(logic [7:0] s);
    return {s[7], s[6], s[5], s[4:3], s[1] & s[6], s[0] & s[5]};
  endfunction : dec
  task automatic give_verdict;
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // bounded wait for results and idle
  task automatic drain;
    int i;
    for (i = 0; i < 200 && (exp_q.size() != 0 || !(req_ready || req.live)); i++)
      @(negedge clk);
    if (i == 200) begin
      `CHK("timeout", 1'b0, 1'b1)
      give_verdict;
    end
  endtask : drain
  task automatic send(logic enh, logic live, logic trm, logic [7:0] die, logic [7:0] s);
    int i;
    @(negedge clk);
    req = '{enhanced: enh, live: live, to_read_mode: trm, row: {die, 16'($random(seed))}};
    exp_q.push_back(dec(s));
    req_valid = 1'b1;
    for (i = 0; i < 50 && !req_ready; i++) @(negedge clk);
    if (i == 50) begin
      `CHK("req_timeout", 1'b0, 1'b1)
      give_verdict;
    end
    @(negedge clk);
    req_valid = 1'b0;
    drain;
  endtask : send
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    // every ecc code with random flags, plain read of die 0
    for (k = 0; k < 8; k++) begin
      s0 = 8'($random(seed));
      s0[4:3] = k[1:0];
      send(1'b0, 1'b0, 1'b0, 8'h00, s0);
      `CHK("busy_n", s0[6] & s1[6], busy_n)
    end
    // enhanced read of busy die 1, then plain read follows it
    s1 = 8'h83;
    send(1'b1, 1'b0, 1'b0, 8'h01, s1);
    send(1'b0, 1'b0, 1'b0, 8'h00, s1);
    // back to die 0, then read mode ends status output
    send(1'b1, 1'b0, 1'b1, 8'h00, s0);
    `CHK("read_mode", 1'b1, dm0)
    // live tracking of a die going ready with a failure
    s0 = 8'h80;
    send(1'b0, 1'b1, 1'b0, 8'h00, s0);
    s0 = 8'he1;
    exp_q.push_back(dec(s0));
    drain;
    s0 = 8'he2;
    exp_q.push_back(dec(s0));
    drain;
    live_stop = 1'b1;
    req.live = 1'b0;
    drain;
    live_stop = 1'b0;
    send(1'b0, 1'b0, 1'b0, 8'h00, s0);
    give_verdict;
  end
endmodule : nds_host_bench
bind nds_host nds_host_assertions #(.STROBE_CYC(STROBE_CYC), .WHR_CYC(WHR_CYC))
  i_nds_host_assertions (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID),
  .REQ_READY(REQ_READY), .REQ(REQ), .STAT_VALID(STAT_VALID), .STAT(STAT),
  .BUSY_N(BUSY_N), .PINS(PINS), .DQ_IN(DQ_IN), .RB_N(RB_N));
